// *** verilog/parallel_port_handshake_ctrl.sv ***
`timescale 1ns/100ps
`include "port_ctrl_map.svh"
module parallel_port_handshake_ctrl #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host bus
    input wire logic chip_enable_n,
    input wire logic io_request_n,
    input wire logic read_n,
    input wire logic opcode_fetch_cycle_n,
    input wire logic port_sel_b,
    input wire logic ctrl_sel,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rdata_oe,
    // Interrupt request, active low drive to open drain
    output logic int_req_n,
    output logic int_req_oe,
    // Port A lines
    input wire logic [WIDTH-1:0] port_a_in,
    output logic [WIDTH-1:0] port_a_out,
    output logic [WIDTH-1:0] port_a_oe,
    input wire logic port_a_strobe_in,
    output logic port_a_ready,
    // Port B lines
    input wire logic [WIDTH-1:0] port_b_in,
    output logic [WIDTH-1:0] port_b_out,
    output logic [WIDTH-1:0] port_b_oe,
    input wire logic port_b_strobe_in,
    output logic port_b_ready
);
    initial begin
        if (WIDTH != 8) $error("WIDTH must be 8");
    end

    port_ctrl_pkg::port_mode_t mode_r [2];
    port_ctrl_pkg::next_word_t next_r [2];
    port_ctrl_pkg::port_cfg_t cfg_r [2];
    logic [7:0] out_r [2];
    logic [7:0] in_r [2];
    logic [1:0] ready_r;
    logic [1:0] pend_r;
    logic [1:0] stb_d_r;
    logic [1:0] stb_hi_r [2];
    logic [1:0] mon_d_r;
    logic held_r;
    logic fetch_lone_r;
    logic io_d_r;
    logic rd_d_r;
    logic wsel_r;
    logic rsel_r;
    logic wdata_cyc_r;

    logic access;
    logic wr_cyc;
    logic rd_cyc;
    logic psel;
    logic [1:0] stb;
    logic [1:0] stb_rise;
    logic [1:0] mon;
    logic [7:0] lines [2];
    logic soft_reset;
    logic io_rise;

    // Port-select decode, request taken with chip enable
    assign access = !chip_enable_n && !io_request_n && opcode_fetch_cycle_n;
    assign wr_cyc = access && read_n;
    assign rd_cyc = access && !read_n;
    assign psel = port_sel_b;
    assign stb[0] = !port_a_strobe_in;
    assign stb[1] = !port_b_strobe_in;
    assign lines[0] = port_a_in;
    assign lines[1] = port_b_in;
    assign io_rise = !io_d_r && io_request_n;

    // Monitor equation for one port
    function automatic logic monitor(input port_ctrl_pkg::port_cfg_t c, input logic [7:0] d);
        logic [7:0] act;
        act = (c.level_high ? d : ~d) | c.mask;
        if (c.and_sel) begin
            monitor = (&act) && (c.mask != `MASK_RESET);
        end else begin
            monitor = |(act & ~c.mask);
        end
    endfunction

    // Read mix for bit-control mode
    function automatic logic [7:0] mix(input logic [7:0] dir, input logic [7:0] o, input logic [7:0] i);
        mix = (dir & i) | (~dir & o);
    endfunction

    assign mon[0] = (mode_r[0] == port_ctrl_pkg::MODE_BITS) && monitor(cfg_r[0], port_a_in);
    assign mon[1] = (mode_r[1] == port_ctrl_pkg::MODE_BITS) && monitor(cfg_r[1], port_b_in);

    // Lone opcode fetch arms a reset taken at its release
    assign soft_reset = fetch_lone_r && opcode_fetch_cycle_n;

    // Bus edge trackers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            io_d_r <= 1'b1;
            rd_d_r <= 1'b1;
            wsel_r <= 1'b0;
            rsel_r <= 1'b0;
            wdata_cyc_r <= 1'b0;
            fetch_lone_r <= 1'b0;
        end else begin
            io_d_r <= io_request_n;
            rd_d_r <= read_n || io_request_n;
            if (access) begin
                wsel_r <= psel;
                rsel_r <= psel;
            end
            wdata_cyc_r <= wr_cyc && !ctrl_sel;
            if (!opcode_fetch_cycle_n) begin
                fetch_lone_r <= read_n && io_request_n;
            end else begin
                fetch_lone_r <= 1'b0;
            end
        end
    end

    // Held in reset until a control word is written
    always_ff @(posedge mclk) begin
        if (!rst_n || soft_reset) begin
            held_r <= 1'b1;
        end else if (wr_cyc && ctrl_sel) begin
            held_r <= 1'b0;
        end
    end

    // Control word decode per port
    always_ff @(posedge mclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!rst_n || soft_reset) begin
                mode_r[p] <= port_ctrl_pkg::MODE_IN;
                next_r[p] <= port_ctrl_pkg::NEXT_CMD;
                cfg_r[p].enable <= 1'b0;
                cfg_r[p].and_sel <= 1'b0;
                cfg_r[p].level_high <= 1'b0;
                cfg_r[p].mask <= `MASK_RESET;
                cfg_r[p].dir <= `DIR_RESET;
                // Vector kept across the lone-fetch reset only
                if (!rst_n) cfg_r[p].vector <= 7'h00;
            end else if (wr_cyc && ctrl_sel && (psel == p[0])) begin
                case (next_r[p])
                    port_ctrl_pkg::NEXT_DIR: begin
                        cfg_r[p].dir <= host_wdata;
                        next_r[p] <= port_ctrl_pkg::NEXT_CMD;
                    end
                    port_ctrl_pkg::NEXT_MASK: begin
                        cfg_r[p].mask <= host_wdata;
                        next_r[p] <= port_ctrl_pkg::NEXT_CMD;
                    end
                    default: begin
                        if (host_wdata[3:0] == `MODE_NIBBLE) begin
                            // Port B cannot take bidirectional mode
                            if (!(p == 1 && host_wdata[7:6] == 2'h2)) begin
                                mode_r[p] <= port_ctrl_pkg::port_mode_t'(host_wdata[7:6]);
                            end
                            if (host_wdata[7:6] == 2'h3) next_r[p] <= port_ctrl_pkg::NEXT_DIR;
                        end else if (host_wdata[3:0] == `ENABLE_NIBBLE) begin
                            cfg_r[p].enable <= host_wdata[`BIT_ENABLE];
                        end else if (host_wdata[3:0] == `ICW_NIBBLE) begin
                            cfg_r[p].enable <= host_wdata[`BIT_ENABLE];
                            cfg_r[p].and_sel <= host_wdata[`BIT_ANDOR];
                            cfg_r[p].level_high <= host_wdata[`BIT_LEVEL];
                            if (host_wdata[`BIT_MASKNEXT]) next_r[p] <= port_ctrl_pkg::NEXT_MASK;
                        end else if (!host_wdata[0]) begin
                            cfg_r[p].vector <= host_wdata[7:1];
                        end
                    end
                endcase
            end
        end
    end

    // Output registers, writable in any mode once out of reset
    always_ff @(posedge mclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!rst_n || soft_reset) begin
                out_r[p] <= `DATA_RESET;
            end else if (wr_cyc && !ctrl_sel && psel == p[0] && !held_r) begin
                out_r[p] <= host_wdata;
            end
        end
    end

    // Input registers load while strobe low, ready ignored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            in_r[0] <= `DATA_RESET;
            in_r[1] <= `DATA_RESET;
        end else begin
            if (mode_r[0] == port_ctrl_pkg::MODE_IN && stb[0]) in_r[0] <= port_a_in;
            if (mode_r[0] == port_ctrl_pkg::MODE_BIDIR && stb[1]) in_r[0] <= port_a_in;
            if (mode_r[1] == port_ctrl_pkg::MODE_IN && stb[1]) in_r[1] <= port_b_in;
            // Bit-control inputs sampled until the read begins
            if (mode_r[0] == port_ctrl_pkg::MODE_BITS && rd_d_r) in_r[0] <= port_a_in;
            if (mode_r[1] == port_ctrl_pkg::MODE_BITS && rd_d_r) in_r[1] <= port_b_in;
        end
    end

    // Strobe edge tracking with high-time filter
    always_ff @(posedge mclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!rst_n) begin
                stb_d_r[p] <= 1'b0;
                stb_hi_r[p] <= `MIN_STB_HIGH; // Saturated, so an idle strobe gives no event
                mon_d_r[p] <= 1'b0;
            end else begin
                stb_d_r[p] <= stb[p];
                mon_d_r[p] <= mon[p];
                if (stb[p]) begin
                    stb_hi_r[p] <= 2'h0;
                end else if (stb_hi_r[p] != `MIN_STB_HIGH) begin
                    stb_hi_r[p] <= stb_hi_r[p] + 2'h1;
                end
            end
        end
    end
    assign stb_rise[0] = stb_d_r[0] && !stb[0];
    assign stb_rise[1] = stb_d_r[1] && !stb[1];

    // Pending interrupts: qualified strobe edge or monitor rising
    always_ff @(posedge mclk) begin
        for (int p = 0; p < 2; p++) begin
            logic ev;
            logic hs;
            ev = 1'b0;
            // Counted once the strobe has stayed high; a looped ready pulse is too short
            hs = !stb[p] && stb_hi_r[p] == (`MIN_STB_HIGH - 2'h1) && opcode_fetch_cycle_n;
            if (mode_r[p] != port_ctrl_pkg::MODE_BITS && hs) ev = 1'b1;
            if (mode_r[p] == port_ctrl_pkg::MODE_BITS && mon[p] && !mon_d_r[p] && opcode_fetch_cycle_n) ev = 1'b1;
            if (!rst_n || soft_reset) begin
                pend_r[p] <= 1'b0;
            end else if (ev) begin
                pend_r[p] <= 1'b1;
            end else if (wr_cyc && ctrl_sel && psel == p[0] && next_r[p] == port_ctrl_pkg::NEXT_CMD
                         && host_wdata[3:0] == `ICW_NIBBLE && host_wdata[`BIT_MASKNEXT]) begin
                pend_r[p] <= 1'b0;
            end
        end
    end

    // Ready lines update on falling mclk edges
    always_ff @(negedge mclk) begin
        if (!rst_n || soft_reset) begin
            ready_r <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                logic out_side;
                logic in_side;
                out_side = (mode_r[p] == port_ctrl_pkg::MODE_OUT) || (p == 0 && mode_r[0] == port_ctrl_pkg::MODE_BIDIR);
                in_side = (mode_r[p] == port_ctrl_pkg::MODE_IN) || (p == 1 && mode_r[0] == port_ctrl_pkg::MODE_BIDIR);
                if (p == 0 && mode_r[0] == port_ctrl_pkg::MODE_BITS) begin
                    ready_r[p] <= 1'b0;
                end else if (p == 1 && mode_r[1] == port_ctrl_pkg::MODE_BITS && mode_r[0] != port_ctrl_pkg::MODE_BIDIR) begin
                    ready_r[p] <= 1'b0;
                end else if (out_side && wdata_cyc_r && wsel_r == p[0]) begin
                    ready_r[p] <= 1'b1;
                end else if (out_side && wr_cyc && !ctrl_sel && psel == p[0] && ready_r[p]) begin
                    ready_r[p] <= 1'b0;
                end else if (in_side && rd_cyc && (p == 1 ? (mode_r[0] == port_ctrl_pkg::MODE_BIDIR ? !psel : psel) : !psel)) begin
                    ready_r[p] <= 1'b0;
                end else if (in_side && io_rise && !rd_d_r
                             && rsel_r == (p == 1 && mode_r[0] != port_ctrl_pkg::MODE_BIDIR)) begin
                    ready_r[p] <= 1'b1;
                end else if (stb_rise[p] && (out_side || in_side)) begin
                    ready_r[p] <= 1'b0;
                end
            end
        end
    end

    // Host read data and interrupt output
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            host_rdata <= 8'h00;
            host_rdata_oe <= 1'b0;
            int_req_n <= 1'b1;
            int_req_oe <= 1'b0;
        end else begin
            host_rdata_oe <= rd_cyc && !ctrl_sel;
            if (access && !read_n) begin
                case (mode_r[psel])
                    port_ctrl_pkg::MODE_OUT: host_rdata <= out_r[psel];
                    port_ctrl_pkg::MODE_BITS: host_rdata <= mix(cfg_r[psel].dir, out_r[psel], in_r[psel]);
                    port_ctrl_pkg::MODE_BIDIR: host_rdata <= stb[0] ? out_r[0] : in_r[0];
                    default: host_rdata <= in_r[psel];
                endcase
            end else if (!io_request_n && !opcode_fetch_cycle_n) begin
                host_rdata <= {(pend_r[0] && cfg_r[0].enable) ? cfg_r[0].vector : cfg_r[1].vector, 1'b0};
                host_rdata_oe <= 1'b1;
            end
            int_req_oe <= (pend_r[0] && cfg_r[0].enable) || (pend_r[1] && cfg_r[1].enable);
            int_req_n <= 1'b0;
        end
    end

    // Port line drivers
    always_ff @(posedge mclk) begin
        if (!rst_n || soft_reset) begin
            port_a_out <= `DATA_RESET;
            port_a_oe <= 8'h00;
            port_b_out <= `DATA_RESET;
            port_b_oe <= 8'h00;
        end else begin
            port_a_out <= out_r[0];
            port_b_out <= out_r[1];
            case (mode_r[0])
                port_ctrl_pkg::MODE_OUT: port_a_oe <= 8'hff;
                port_ctrl_pkg::MODE_BIDIR: port_a_oe <= stb[0] ? 8'hff : 8'h00;
                port_ctrl_pkg::MODE_BITS: port_a_oe <= ~cfg_r[0].dir;
                default: port_a_oe <= 8'h00;
            endcase
            case (mode_r[1])
                port_ctrl_pkg::MODE_OUT: port_b_oe <= 8'hff;
                port_ctrl_pkg::MODE_BITS: port_b_oe <= ~cfg_r[1].dir;
                default: port_b_oe <= 8'h00;
            endcase
        end
    end

    assign port_a_ready = ready_r[0];
    assign port_b_ready = ready_r[1];
endmodule

// *** shared/port_ctrl_map.svh ***
// How it works
// - Control word with low nibble 1111 sets mode from bits 7:6; bits 5:4 ignored
// - Output mode drives output register onto lines; read returns output register
// - Output mode data write raises ready; strobe rising edge clears it, interrupts
// - Input mode host read raises ready; strobe rise clears it and interrupts
// - Strobed input data is accepted whatever the ready state
// - Bidirectional only on port A; A handshake output side, B handshake input side, data on A lines
// - Bidirectional mode drives port A lines only while A strobe is low
// - After bit-control select, next control word is direction, 1 means input
// - Bit-control mode ignores strobe and holds ready low, except port B while port A is bidirectional
// - Bit-control read mixes live input lines and output register bits
// - Bit 7 sets enable; interrupts seen while disabled stay pending
// - Bit 4 clears pending interrupt; next control word becomes monitor mask
// - Bit 6 picks AND of all unmasked lines or OR of any
// - Bit 5 sets active level of monitored lines, 1 high
// - Mask bit 0 means line is monitored, 1 excludes it
// - Low nibble 0011 changes only the interrupt enable from bit 7
// - Ready rises on falling clock after output register write
// - Ready already high on output write drops briefly then rises again
// - Strobe high pulses seen on fewer than two rising clock edges raise no interrupt
// - Output register may be written before output mode is entered
// - Input strobe low loads register; ready follows strobe and read edges
// - Ready high during input read is forced low until request ends
// - Opcode fetch alone resets device on its release until a control word
// - Reset: input mode, all masked, enables and outputs cleared, lines float
// - Control word with bit 0 low stores vector bits 7:1
// - Chip enable and request select port by port select, control by c/d
`ifndef PORT_CTRL_MAP_SVH
`define PORT_CTRL_MAP_SVH
`define MODE_NIBBLE 4'hf
`define ENABLE_NIBBLE 4'h3
`define ICW_NIBBLE 4'h7
`define BIT_ENABLE 7
`define BIT_ANDOR 6
`define BIT_LEVEL 5
`define BIT_MASKNEXT 4
`define MASK_RESET 8'hff
`define DATA_RESET 8'h00
`define DIR_RESET 8'hff
`define MIN_STB_HIGH 2'h2
`endif

// *** shared/port_ctrl_pkg.sv ***
package port_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_OUT = 2'h0,
        MODE_IN = 2'h1,
        MODE_BIDIR = 2'h2,
        MODE_BITS = 2'h3
    } port_mode_t;
    // What the next control word will be taken as, one-hot
    typedef enum logic [2:0] {
        NEXT_CMD = 3'h1,
        NEXT_DIR = 3'h2,
        NEXT_MASK = 3'h4
    } next_word_t;
    typedef struct packed {
        logic enable;
        logic and_sel;
        logic level_high;
        logic [7:0] mask;
        logic [7:0] dir;
        logic [6:0] vector;
    } port_cfg_t;
endpackage

// *** testbench/port_ctrl_checker.sv ***
`timescale 1ns/100ps
module port_ctrl_checker #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host bus
    input wire logic chip_enable_n,
    input wire logic io_request_n,
    input wire logic read_n,
    input wire logic opcode_fetch_cycle_n,
    input wire logic port_sel_b,
    input wire logic ctrl_sel,
    input wire logic [7:0] host_wdata,
    input wire logic host_rdata_oe,
    input wire logic int_req_oe,
    // Port lines and handshakes
    input wire logic [WIDTH-1:0] port_a_oe,
    input wire logic [WIDTH-1:0] port_b_oe,
    input wire logic port_a_strobe_in,
    input wire logic port_a_ready,
    input wire logic port_b_ready
);
    port_ctrl_pkg::port_mode_t mode_a_r;
    logic skip_r;
    logic acc;
    logic wr_a;
    assign acc = !chip_enable_n && !io_request_n && opcode_fetch_cycle_n;
    assign wr_a = acc && read_n && !port_sel_b;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Direction and mask words follow some control words; they are no mode words
    always_ff @(posedge mclk) begin
        if (!rst_n)
            skip_r <= 1'b0;
        else if (wr_a && ctrl_sel)
            skip_r <= !skip_r && (host_wdata == 8'hcf || host_wdata == 8'hdf || host_wdata == 8'hef ||
                host_wdata == 8'hff || (host_wdata[3:0] == 4'h7 && host_wdata[4]));
    end

    // Port A mode as the host set it; a lone fetch falls back to input
    always_ff @(posedge mclk) begin
        if (!rst_n || ($rose(opcode_fetch_cycle_n) && read_n && io_request_n))
            mode_a_r <= port_ctrl_pkg::MODE_IN;
        else if (wr_a && ctrl_sel && !skip_r && host_wdata[3:0] == 4'hf)
            mode_a_r <= port_ctrl_pkg::port_mode_t'(host_wdata[7:6]);
    end

    a_reset_quiet: assert property ($rose(rst_n) |-> !port_a_ready && !port_b_ready && port_a_oe == '0)
        else $error("ready or lines active after reset");
    a_reset_noint: assert property ($rose(rst_n) |-> (!int_req_oe)[*8])
        else $error("interrupt right after reset");
    a_read_answer: assert property (acc && !read_n && !ctrl_sel |=> host_rdata_oe)
        else $error("read not answered");
    a_out_drives: assert property ((mode_a_r == port_ctrl_pkg::MODE_OUT)[*2] |-> port_a_oe == '1)
        else $error("output mode lines not driven");
    a_bidir_float: assert property ((mode_a_r == port_ctrl_pkg::MODE_BIDIR && port_a_strobe_in)[*3] |-> port_a_oe == '0)
        else $error("bidirectional lines driven without strobe");
    a_bidir_drive: assert property ((mode_a_r == port_ctrl_pkg::MODE_BIDIR && !port_a_strobe_in)[*3] |-> port_a_oe == '1)
        else $error("bidirectional lines idle under strobe");
    a_bits_ready: assert property ((mode_a_r == port_ctrl_pkg::MODE_BITS)[*2] |-> !port_a_ready)
        else $error("ready high in bit control");
    a_out_ready: assert property (mode_a_r == port_ctrl_pkg::MODE_OUT && wr_a && !ctrl_sel |-> ##[1:4] port_a_ready)
        else $error("output write raised no ready");
    a_in_ready: assert property (mode_a_r == port_ctrl_pkg::MODE_IN && acc && !read_n && !port_sel_b && !ctrl_sel
        && port_a_strobe_in |-> ##[2:5] port_a_ready)
        else $error("input read raised no ready");
    a_strobe_drop: assert property (mode_a_r != port_ctrl_pkg::MODE_BITS && !port_a_strobe_in ##1 port_a_strobe_in
        |-> !port_a_ready)
        else $error("strobe rise left ready high");

    // Main scenarios reached
    c_bits_int: cover property (mode_a_r == port_ctrl_pkg::MODE_BITS && int_req_oe);
    c_bidir_out: cover property (mode_a_r == port_ctrl_pkg::MODE_BIDIR && port_a_oe == '1);
    c_both_ready: cover property (port_a_ready && port_b_ready);
endmodule

bind parallel_port_handshake_ctrl port_ctrl_checker #(.WIDTH(WIDTH)) u_port_ctrl_checker (.mclk(mclk), .rst_n(rst_n),
    .chip_enable_n(chip_enable_n), .io_request_n(io_request_n), .read_n(read_n),
    .opcode_fetch_cycle_n(opcode_fetch_cycle_n), .port_sel_b(port_sel_b), .ctrl_sel(ctrl_sel), .host_wdata(host_wdata),
    .host_rdata_oe(host_rdata_oe), .int_req_oe(int_req_oe), .port_a_oe(port_a_oe), .port_b_oe(port_b_oe),
    .port_a_strobe_in(port_a_strobe_in), .port_a_ready(port_a_ready), .port_b_ready(port_b_ready));

// *** testbench/port_periph_model.sv ***
`timescale 1ns/100ps
module port_periph_model (
    // Clock
    input wire logic mclk,
    // Handshake with the device
    input wire logic ready,
    output logic strobe_n,
    output logic [7:0] lines,
    // Bench controls
    input wire logic auto_ack,
    input wire logic [3:0] ack_delay,
    input wire logic manual_low,
    input wire logic steady,
    input wire logic [7:0] data_val
);
    logic strobe_r = 1'b1;

    // Strobe only after ready, so the input register is never overrun
    always begin
        @(posedge mclk);
        if (auto_ack && ready) begin
            repeat (ack_delay) @(posedge mclk);
            #2 strobe_r = 1'b0;
            repeat (3) @(posedge mclk);
            #2 strobe_r = 1'b1;
            repeat (2) @(posedge mclk);
        end
    end

    // Released lines show the inverse unless steady is set, so stale data cannot pass unseen
    assign strobe_n = strobe_r && !manual_low;
    assign lines = (steady || !strobe_n) ? data_val : ~data_val;
endmodule

// *** testbench/parallel_port_handshake_ctrl_tb.sv ***
`timescale 1ns/100ps
module parallel_port_handshake_ctrl_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic chip_enable_n = 1'b1;
    logic io_request_n = 1'b1;
    logic read_n = 1'b1;
    logic opcode_fetch_cycle_n = 1'b1;
    logic port_sel_b = 1'b0;
    logic ctrl_sel = 1'b0;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] host_rdata, port_a_out, port_a_oe, port_b_out, port_b_oe, a_lines, b_lines, a_pin, b_pin, rd;
    logic host_rdata_oe, int_req_n, int_req_oe, port_a_ready, port_b_ready, a_strobe_n, b_strobe_n;
    logic a_auto = 1'b0, a_low = 1'b0, b_low = 1'b0, a_steady = 1'b0;
    logic [3:0] a_dly = 4'h1;
    logic [7:0] a_val = 8'h00;
    logic [7:0] icw_tab [3] = '{8'h37, 8'h77, 8'h17};
    logic [7:0] mask_tab [3] = '{8'hef, 8'hcf, 8'hbf};
    logic [7:0] idle_tab [3] = '{8'h2f, 8'h10, 8'hff};
    logic [7:0] fire_tab [3] = '{8'h10, 8'h30, 8'hbf};
    int bad_count = 0;
    int samples_checked = 0;

    // 20 MHz clock
    always #25 mclk = ~mclk;

    // Pin level: the device wins wherever it drives
    assign a_pin = (port_a_oe & port_a_out) | (~port_a_oe & a_lines);
    assign b_pin = (port_b_oe & port_b_out) | (~port_b_oe & b_lines);

    parallel_port_handshake_ctrl u_parallel_port_handshake_ctrl (.mclk(mclk), .rst_n(rst_n),
        .chip_enable_n(chip_enable_n), .io_request_n(io_request_n), .read_n(read_n),
        .opcode_fetch_cycle_n(opcode_fetch_cycle_n), .port_sel_b(port_sel_b), .ctrl_sel(ctrl_sel),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe), .int_req_n(int_req_n),
        .int_req_oe(int_req_oe), .port_a_in(a_pin), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
        .port_a_strobe_in(a_strobe_n), .port_a_ready(port_a_ready), .port_b_in(b_pin), .port_b_out(port_b_out),
        .port_b_oe(port_b_oe), .port_b_strobe_in(b_strobe_n), .port_b_ready(port_b_ready));
    port_periph_model u_port_periph_model_a (.mclk(mclk), .ready(port_a_ready), .strobe_n(a_strobe_n),
        .lines(a_lines), .auto_ack(a_auto), .ack_delay(a_dly), .manual_low(a_low), .steady(a_steady), .data_val(a_val));
    port_periph_model u_port_periph_model_b (.mclk(mclk), .ready(port_b_ready), .strobe_n(b_strobe_n),
        .lines(b_lines), .auto_ack(1'b0), .ack_delay(4'h1), .manual_low(b_low), .steady(1'b0), .data_val(8'h00));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One host cycle; the request is held over one sampling edge
    task automatic access(input logic b, input logic c, input logic rnw, input logic [7:0] d);
        @(posedge mclk);
        #2 {chip_enable_n, io_request_n, read_n, port_sel_b, ctrl_sel, host_wdata} = {2'b00, !rnw, b, c, d};
        @(posedge mclk);
        #2 {chip_enable_n, io_request_n, read_n} = 3'b111;
        @(posedge mclk);
        #2 rd = host_rdata;
    endtask

    task automatic wr(input logic b, input logic c, input logic [7:0] d);
        access(b, c, 1'b0, d);
    endtask

    task automatic rdchk(input logic b, input logic [7:0] exp);
        access(b, 1'b0, 1'b1, 8'h00);
        check(rd, exp);
    endtask

    // Bounded wait for a ready or interrupt level
    task automatic poll(input int sel, input logic exp);
        logic v;
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #2 v = sel == 0 ? port_a_ready : (sel == 1 ? port_b_ready : int_req_oe);
            if (v === exp)
                break;
        end
        check({7'h00, v}, {7'h00, exp});
    endtask

    task automatic pulse(input logic b, input int n);
        #2 {b_low, a_low} = {b, !b};
        repeat (n) @(posedge mclk);
        #2 {b_low, a_low} = 2'b00;
    endtask

    // Drops port A's pending request, disables and masks every port A line
    task automatic clr();
        wr(0, 1, 8'h17);
        wr(0, 1, 8'hff);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog well above the expected run of about 250 cycles
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge mclk);
        #2 rst_n = 1'b1;
        check({6'h00, port_a_ready, port_b_ready}, 8'h00);
        check(port_a_oe | port_b_oe, 8'h00);
        wr(0, 1, 8'h20);
        wr(0, 0, 8'ha5);
        wr(0, 1, 8'h3f);
        check(port_a_oe, 8'hff);
        check(port_a_out, 8'ha5);
        rdchk(0, 8'ha5);
        // Output handshake, rewrite while ready is high, then acknowledge
        wr(0, 0, 8'h3c);
        poll(0, 1);
        wr(0, 0, 8'h3d);
        poll(0, 1);
        wr(0, 1, 8'h87);
        a_auto = 1'b1;
        poll(0, 0);
        poll(2, 1);
        a_auto = 1'b0;
        clr();
        poll(2, 0);
        // A one-cycle high glitch on the strobe must not interrupt
        wr(0, 1, 8'h83);
        pulse(0, 3);
        @(posedge mclk);
        pulse(0, 4);
        check({7'h00, int_req_oe}, 8'h00);
        poll(2, 1);
        clr();
        // Event while disabled stays pending until enable-only word
        wr(0, 0, 8'h11);
        a_auto = 1'b1;
        poll(0, 0);
        a_auto = 1'b0;
        repeat (4) @(posedge mclk);
        check({7'h00, int_req_oe}, 8'h00);
        wr(0, 1, 8'h83);
        poll(2, 1);
        clr();
        // Input mode, slow peripheral, then a load while ready is low
        a_dly = 4'h6;
        a_val = 8'h5a;
        wr(0, 1, 8'h4f);
        access(0, 0, 1, 8'h00);
        poll(0, 1);
        a_auto = 1'b1;
        poll(0, 0);
        a_auto = 1'b0;
        a_val = 8'hc3;
        pulse(0, 3);
        rdchk(0, 8'hc3);
        // Bidirectional on port A with B handshake for input
        wr(0, 1, 8'h8f);
        wr(0, 0, 8'h77);
        check(port_a_oe, 8'h00);
        access(0, 0, 1, 8'h00);
        poll(1, 1);
        check({6'h00, port_a_ready, port_b_ready}, 8'h03);
        pulse(0, 3);
        @(posedge mclk);
        #2 check(port_a_oe, 8'h00);
        poll(0, 0);
        pulse(1, 3);
        poll(1, 0);
        rdchk(0, 8'h3c);
        wr(0, 0, 8'h55);
        check(port_a_ready, 1'b1);
        // Bit control: direction word, mixed read, ready held low
        a_steady = 1'b1;
        a_val = 8'h9c;
        wr(0, 1, 8'hcf);
        wr(0, 1, 8'hf0);
        wr(0, 0, 8'h5a);
        poll(0, 0);
        check(port_a_oe, 8'h0f);
        rdchk(0, 8'h9a);
        for (int i = 0; i < 3; i++) begin
            clr();
            a_val = idle_tab[i];
            wr(0, 1, icw_tab[i]);
            wr(0, 1, mask_tab[i]);
            wr(0, 1, 8'h83);
            repeat (4) @(posedge mclk);
            check({7'h00, int_req_oe}, 8'h00);
            #2 a_val = fire_tab[i];
            poll(2, 1);
        end
        clr();
        // Lone opcode fetch resets; data is refused until a control word
        #2 opcode_fetch_cycle_n = 1'b0;
        @(posedge mclk);
        #2 opcode_fetch_cycle_n = 1'b1;
        repeat (2) @(posedge mclk);
        check(port_a_oe, 8'h00);
        check({6'h00, port_a_ready, port_b_ready}, 8'h00);
        wr(0, 0, 8'h11);
        wr(0, 1, 8'h0f);
        check(port_a_out, 8'h00);
        wr(1, 1, 8'h0f);
        wr(1, 0, 8'h42);
        check(port_b_out, 8'h42);
        check(port_a_out, 8'h00);
        poll(1, 1);
        complete_run();
    end
endmodule
